// *** gpio_led_map.svh ***
// Purpose: Offsets, field positions and reset values for the pin function block
// Assumes: APB slave, 32-bit words, byte addresses as printed
// Notes: Types live in gpio_led_pkg
// How it works
// - A set lamp select bit in 30:28 turns its pin into a lamp output, clear leaves it general purpose.
// - A set polarity bit in 26:24 makes a high level the active one, clear makes a low level active.
// - A pin interrupt reaches the host only when its enable bit is also set.
// - The rom pin select field sits in 22:20 with bit 22 most significant.
// - Codes 000, 001, 011, 101, 110, 111 pick the data and clock pin functions as listed.
// - Monitored receive strobes and clocks come from the internal phy, transmit enable from the mac.
// - A set driver type bit in 18:16 gives push-pull, clear gives open-drain.
// - A set direction bit in 10:8 makes the pin an output, clear an input.
// - Bits 3 and 4 drive out-only pins a and b when the select field routes them out.
// - Writes to bits 2:0 drive output pins, reads return the live level of every pin.
`ifndef GPIO_LED_MAP_SVH
`define GPIO_LED_MAP_SVH
`define PIN_CFG_ADDR      12'h088
`define IRQ_STATUS_ADDR   12'h0c0
`define IRQ_ENABLE_ADDR   12'h0c4
`define CFG_WRITE_MASK    32'h7777071f
`define LAMP_LSB          28
`define POL_LSB           24
`define SEL_LSB           20
`define DRV_LSB           16
`define DIR_LSB           8
`define OUTA_BIT          3
`define OUTB_BIT          4
`define CFG_RESET         32'h00000000
`define MIN_PULSE_NS      40
`define CLK_PERIOD_NS     4
`define MIN_PULSE_CYC     ((`MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// *** gpio_led_pkg.sv ***
// Purpose: Types for the pin function block
// Assumes: Nothing beyond the constants header
// Notes: Select codes follow the pin table
package gpio_led_pkg;
   typedef enum logic [2:0] {
      SEL_ROM       = 3'h0,
      SEL_OUT_AB    = 3'h1,
      SEL_RES_2     = 3'h2,
      SEL_OUTA_RXDV = 3'h3,
      SEL_RES_4     = 3'h4,
      SEL_TXEN_OUTB = 3'h5,
      SEL_TXEN_RXDV = 3'h6,
      SEL_CLOCKS    = 3'h7
   } rom_sel_type;

   typedef struct packed {
      logic [31:0] cfg;
      logic [2:0]  sync1;
      logic [2:0]  sync2;
      logic [2:0]  irq_status;
      logic [2:0]  irq_enable;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        irq;
      logic [2:0]  pin_out;
      logic [2:0]  pin_oe;
      logic        data_out;
      logic        data_oe;
      logic        clock_out;
   } state_type;
endpackage

// *** gpio_led_pin_config.sv ***
// Purpose: Pin function register, general pins, lamp outputs and rom pin mux
// Assumes: APB master, pins synchronous to pclk after two flops
// Notes: Interrupt status and enable live here as two extra words
//
// The APB register port was decided locally.
`include "gpio_led_map.svh"

module gpio_led_pin_config (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   input  wire logic [2:0]  pin_in,
   output logic [2:0]       pin_out,
   output logic [2:0]       pin_oe,
   input  wire logic [2:0]  lamp_in,
   input  wire logic        rom_do,
   input  wire logic        rom_do_oe,
   input  wire logic        rom_clk,
   input  wire logic        phy_rx_dv,
   input  wire logic        phy_tx_clk,
   input  wire logic        phy_rx_clk,
   input  wire logic        mac_tx_en,
   output logic             rom_data_pin_out,
   output logic             rom_data_pin_oe,
   output logic             rom_clock_pin_out
);
   gpio_led_pkg::state_type st_reg, st_next;

   // One pin's drive, lamp or general; open-drain only pulls low
   function automatic logic [1:0] drive(input logic lamp, input logic lamp_v, input logic dir,
                                         input logic pp, input logic v);
      logic val;
      logic en;
      val = lamp ? lamp_v : v;
      en  = lamp | dir;
      if (!pp)
         return {1'b0, en & ~val};
      return {val, en};
   endfunction

   always_comb begin
      logic        acc;
      logic [2:0]  pol;
      logic [2:0]  hit;
      logic [1:0]  d;
      gpio_led_pkg::rom_sel_type sel;
      // Locals start from known values so nothing holds over between passes
      acc = 1'h0;
      pol = 3'h0;
      hit = 3'h0;
      d   = 2'h0;
      sel = gpio_led_pkg::SEL_ROM;
      st_next = st_reg;
      acc = psel & penable;
      // Two flop synchroniser for pins
      st_next.sync1 = pin_in;
      st_next.sync2 = st_reg.sync1;
      pol = st_reg.cfg[`POL_LSB +: 3];
      hit = ~(st_reg.sync2 ^ pol);
      st_next.pready  = acc & ~st_reg.pready;
      st_next.pslverr = 1'b0;
      st_next.prdata  = 32'h00000000;
      // Bus access, one wait state
      if (acc && !st_reg.pready) begin
         unique case (paddr)
            `PIN_CFG_ADDR: begin
               if (pwrite)
                  st_next.cfg = pwdata & `CFG_WRITE_MASK;
               else
                  st_next.prdata = {st_reg.cfg[31:3], st_reg.sync2};
            end
            `IRQ_STATUS_ADDR: begin
               if (!pwrite) begin
                  st_next.prdata = {29'h0, st_reg.irq_status};
                  st_next.irq_status = 3'h0;
               end
            end
            `IRQ_ENABLE_ADDR: begin
               if (pwrite)
                  st_next.irq_enable = pwdata[2:0];
               else
                  st_next.prdata = {29'h0, st_reg.irq_enable};
            end
            default: st_next.pslverr = 1'b1;
         endcase
      end
      // Set wins over read clear
      st_next.irq_status = st_next.irq_status | hit;
      st_next.irq = |(st_next.irq_status & st_next.irq_enable);
      for (int i = 0; i < 3; i++) begin
         d = drive(st_next.cfg[`LAMP_LSB + i], lamp_in[i], st_next.cfg[`DIR_LSB + i],
                   st_next.cfg[`DRV_LSB + i], st_next.cfg[i]);
         st_next.pin_out[i] = d[1];
         st_next.pin_oe[i]  = d[0];
      end
      // Rom pin mux; reserved codes leave pins idle
      sel = gpio_led_pkg::rom_sel_type'(st_next.cfg[`SEL_LSB +: 3]);
      st_next.data_out  = 1'b0;
      st_next.data_oe   = 1'b0;
      st_next.clock_out = 1'b0;
      unique case (sel)
         gpio_led_pkg::SEL_ROM: begin
            st_next.data_out = rom_do;
            st_next.data_oe = rom_do_oe;
            st_next.clock_out = rom_clk;
         end
         gpio_led_pkg::SEL_OUT_AB: begin
            st_next.data_out = st_next.cfg[`OUTA_BIT];
            st_next.data_oe = 1'b1;
            st_next.clock_out = st_next.cfg[`OUTB_BIT];
         end
         gpio_led_pkg::SEL_OUTA_RXDV: begin
            st_next.data_out = st_next.cfg[`OUTA_BIT];
            st_next.data_oe = 1'b1;
            st_next.clock_out = phy_rx_dv;
         end
         gpio_led_pkg::SEL_TXEN_OUTB: begin
            st_next.data_out = mac_tx_en;
            st_next.data_oe = 1'b1;
            st_next.clock_out = st_next.cfg[`OUTB_BIT];
         end
         gpio_led_pkg::SEL_TXEN_RXDV: begin
            st_next.data_out = mac_tx_en;
            st_next.data_oe = 1'b1;
            st_next.clock_out = phy_rx_dv;
         end
         gpio_led_pkg::SEL_CLOCKS: begin
            st_next.data_out = phy_tx_clk;
            st_next.data_oe = 1'b1;
            st_next.clock_out = phy_rx_clk;
         end
         default: begin
            st_next.data_oe = 1'b0;
         end
      endcase
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign prdata            = st_reg.prdata;
   assign pready            = st_reg.pready;
   assign pslverr           = st_reg.pslverr;
   assign irq               = st_reg.irq;
   assign pin_out           = st_reg.pin_out;
   assign pin_oe            = st_reg.pin_oe;
   assign rom_data_pin_out  = st_reg.data_out;
   assign rom_data_pin_oe   = st_reg.data_oe;
   assign rom_clock_pin_out = st_reg.clock_out;

   // Checks
   sequence s_cfg_write;
      psel && penable && pwrite && !pready && paddr == `PIN_CFG_ADDR;
   endsequence

   // Access phase that the slave takes; the wait state keeps pready low here
   sequence s_take;
      psel && penable && !pready;
   endsequence

   sequence s_cfg_read;
      psel && penable && !pwrite && !pready && paddr == `PIN_CFG_ADDR;
   endsequence

   sequence s_stat_read;
      psel && penable && !pwrite && !pready && paddr == `IRQ_STATUS_ADDR;
   endsequence

   sequence s_en_write;
      psel && penable && pwrite && !pready && paddr == `IRQ_ENABLE_ADDR;
   endsequence

   property p_lamp;
      @(posedge pclk) disable iff (!presetn)
      st_reg.cfg[`LAMP_LSB] && st_reg.cfg[`DRV_LSB] |-> pin_oe[0];
   endproperty
   a_lamp: assert property (p_lamp) else $error("lamp pin not driven");

   property p_pol;
      @(posedge pclk) disable iff (!presetn)
      (st_reg.sync2[0] == st_reg.cfg[`POL_LSB]) |=> st_reg.irq_status[0];
   endproperty
   a_pol: assert property (p_pol) else $error("active level missed");

   property p_irq;
      @(posedge pclk) disable iff (!presetn)
      irq |-> |(st_reg.irq_status & st_reg.irq_enable);
   endproperty
   a_irq: assert property (p_irq) else $error("irq without enabled status");

   property p_sync;
      @(posedge pclk) disable iff (!presetn)
      // Two edges out of reset first, else the flops still hold their reset zeros
      $past(presetn, 2) && $past(presetn) |-> st_reg.sync2 == $past(pin_in, 2);
   endproperty
   a_sync: assert property (p_sync) else $error("sync depth wrong");

   property p_cfgw;
      @(posedge pclk) disable iff (!presetn)
      s_cfg_write |=> st_reg.cfg == ($past(pwdata) & `CFG_WRITE_MASK);
   endproperty
   a_cfgw: assert property (p_cfgw) else $error("cfg write lost");

   property p_clocks;
      @(posedge pclk) disable iff (!presetn)
      st_reg.cfg[`SEL_LSB +: 3] == gpio_led_pkg::SEL_CLOCKS |-> rom_data_pin_out == $past(phy_tx_clk);
   endproperty
   a_clocks: assert property (p_clocks) else $error("tx clock not routed");

   property p_od;
      @(posedge pclk) disable iff (!presetn)
      !st_reg.cfg[`DRV_LSB] && pin_oe[0] |-> !pin_out[0];
   endproperty
   a_od: assert property (p_od) else $error("open drain drove high");

   property p_dir;
      @(posedge pclk) disable iff (!presetn)
      !st_reg.cfg[`LAMP_LSB + 1] && !st_reg.cfg[`DIR_LSB + 1] |-> !pin_oe[1];
   endproperty
   a_dir: assert property (p_dir) else $error("input pin driven");

   property p_outa;
      @(posedge pclk) disable iff (!presetn)
      st_reg.cfg[`SEL_LSB +: 3] == gpio_led_pkg::SEL_OUT_AB |-> rom_data_pin_out == st_reg.cfg[`OUTA_BIT];
   endproperty
   a_outa: assert property (p_outa) else $error("out pin a wrong");

   property p_ready;
      @(posedge pclk) disable iff (!presetn)
      psel && !penable ##1 psel && penable |=> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("no ready");

   // Ready is a one cycle pulse, so a held access cannot be taken twice
   property p_ready_pulse;
      @(posedge pclk) disable iff (!presetn)
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");

   // Unmapped word answers with an error and leaves the config alone
   property p_err;
      @(posedge pclk) disable iff (!presetn)
      s_take ##0 !(paddr inside {`PIN_CFG_ADDR, `IRQ_STATUS_ADDR, `IRQ_ENABLE_ADDR})
         |=> pslverr && pready && $stable(st_reg.cfg);
   endproperty
   a_err: assert property (p_err) else $error("unmapped access not refused");

   // Config read returns stored fields over the synchronised pin levels
   property p_cfg_read;
      @(posedge pclk) disable iff (!presetn)
      s_cfg_read |=> prdata == {$past(st_reg.cfg[31:3]), $past(st_reg.sync2)};
   endproperty
   a_cfg_read: assert property (p_cfg_read) else $error("cfg read data wrong");

   // Status read hands over the sticky bits as they stood
   property p_stat_read;
      @(posedge pclk) disable iff (!presetn)
      s_stat_read |=> prdata == {29'h0, $past(st_reg.irq_status)};
   endproperty
   a_stat_read: assert property (p_stat_read) else $error("status read data wrong");

   // Read clears the status when no pin sits at its active level
   property p_stat_clear;
      @(posedge pclk) disable iff (!presetn)
      s_stat_read ##0 &(st_reg.sync2 ^ st_reg.cfg[`POL_LSB +: 3]) |=> st_reg.irq_status == 3'h0;
   endproperty
   a_stat_clear: assert property (p_stat_clear) else $error("status not cleared");

   // Enable word is stored as written
   property p_en_write;
      @(posedge pclk) disable iff (!presetn)
      s_en_write |=> st_reg.irq_enable == $past(pwdata[2:0]);
   endproperty
   a_en_write: assert property (p_en_write) else $error("enable write lost");

   // Nothing reaches the host while every enable bit is clear
   property p_masked;
      @(posedge pclk) disable iff (!presetn)
      st_reg.irq_enable == 3'h0 |-> !irq;
   endproperty
   a_masked: assert property (p_masked) else $error("masked irq raised");

   // Push-pull lamp pin follows the lamp state one edge later
   property p_lamp_val;
      @(posedge pclk) disable iff (!presetn)
      st_reg.cfg[`LAMP_LSB] && st_reg.cfg[`DRV_LSB] |-> pin_out[0] == $past(lamp_in[0]);
   endproperty
   a_lamp_val: assert property (p_lamp_val) else $error("lamp value wrong");

   // Push-pull general output carries its data bit
   property p_gp_val;
      @(posedge pclk) disable iff (!presetn)
      !st_reg.cfg[`LAMP_LSB + 1] && st_reg.cfg[`DIR_LSB + 1] && st_reg.cfg[`DRV_LSB + 1]
         |-> pin_oe[1] && pin_out[1] == st_reg.cfg[1];
   endproperty
   a_gp_val: assert property (p_gp_val) else $error("output data wrong");

   // Open-drain output lets go of the pin for a high
   property p_od_release;
      @(posedge pclk) disable iff (!presetn)
      !st_reg.cfg[`LAMP_LSB + 2] && st_reg.cfg[`DIR_LSB + 2] && !st_reg.cfg[`DRV_LSB + 2] && st_reg.cfg[2]
         |-> !pin_oe[2];
   endproperty
   a_od_release: assert property (p_od_release) else $error("open drain held high");

   // Rom engine owns both pins after reset and in code zero
   property p_rom;
      @(posedge pclk) disable iff (!presetn)
      $past(presetn) && st_reg.cfg[`SEL_LSB +: 3] == gpio_led_pkg::SEL_ROM
         |-> rom_data_pin_out == $past(rom_do) && rom_data_pin_oe == $past(rom_do_oe)
             && rom_clock_pin_out == $past(rom_clk);
   endproperty
   a_rom: assert property (p_rom) else $error("rom pins not routed");

   // Out-only pin b on the clock pin
   property p_outb;
      @(posedge pclk) disable iff (!presetn)
      st_reg.cfg[`SEL_LSB +: 3] == gpio_led_pkg::SEL_OUT_AB |-> rom_clock_pin_out == st_reg.cfg[`OUTB_BIT];
   endproperty
   a_outb: assert property (p_outb) else $error("out pin b wrong");

   // Receive strobe comes from the internal phy
   property p_rxdv;
      @(posedge pclk) disable iff (!presetn)
      st_reg.cfg[`SEL_LSB +: 3] == gpio_led_pkg::SEL_OUTA_RXDV |-> rom_clock_pin_out == $past(phy_rx_dv);
   endproperty
   a_rxdv: assert property (p_rxdv) else $error("rx strobe not routed");

   // Transmit enable always comes from the mac
   property p_txen;
      @(posedge pclk) disable iff (!presetn)
      st_reg.cfg[`SEL_LSB +: 3] == gpio_led_pkg::SEL_TXEN_OUTB
         |-> rom_data_pin_out == $past(mac_tx_en) && rom_clock_pin_out == st_reg.cfg[`OUTB_BIT];
   endproperty
   a_txen: assert property (p_txen) else $error("tx enable not routed");

   property p_txen_rxdv;
      @(posedge pclk) disable iff (!presetn)
      st_reg.cfg[`SEL_LSB +: 3] == gpio_led_pkg::SEL_TXEN_RXDV
         |-> rom_data_pin_out == $past(mac_tx_en) && rom_clock_pin_out == $past(phy_rx_dv);
   endproperty
   a_txen_rxdv: assert property (p_txen_rxdv) else $error("monitor pair not routed");

   // Receive clock from the internal phy on the clock pin
   property p_rxclk;
      @(posedge pclk) disable iff (!presetn)
      st_reg.cfg[`SEL_LSB +: 3] == gpio_led_pkg::SEL_CLOCKS |-> rom_clock_pin_out == $past(phy_rx_clk);
   endproperty
   a_rxclk: assert property (p_rxclk) else $error("rx clock not routed");
endmodule

// *** pins_model.sv ***
// Purpose: Pins outside the block, with pull-ups and outside drivers
// Assumes: The block's own drive wins a clash on a pin
// Notes: An undriven pin floats high through its pull-up
module pins_model (
   input  wire logic [2:0] pin_out,
   input  wire logic [2:0] pin_oe,
   input  wire logic [2:0] ext_drv,
   input  wire logic [2:0] ext_val,
   output logic [2:0]      pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Wire level; outside levels are held for many cycles, far above the 40 ns minimum
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_drv[i] ? ext_val[i] : 1'b1);
      end
   end
endmodule

// *** test_gpio_led_pin_config.sv ***
// Purpose: Self-checking bench for the pin function block
// Assumes: Answer after one wait cycle, pins seen after two sync flops
// Notes: Reserved select codes are never written
`include "gpio_led_map.svh"
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin n_mismatch++; \
   $display("BAD %s exp %h got %h", nm, ex, gt); end end
module test_gpio_led_pin_config;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic [2:0]  pin_in;
   logic [2:0]  pin_out;
   logic [2:0]  pin_oe;
   logic [15:0] drv_r;
   logic [15:0] stim;
   logic        d_out;
   logic        d_oe;
   logic        c_out;
   logic [31:0] seed;
   logic [31:0] w;
   logic [31:0] rd;
   logic [2:0]  en;
   logic [2:0]  act;
   logic        er;
   int          n_mismatch = 0;
   int          samples_checked = 0;
   logic [2:0]  codes [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
   gpio_led_pin_config dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .lamp_in(drv_r[2:0]), .rom_do(drv_r[9]),
      .rom_do_oe(drv_r[10]), .rom_clk(drv_r[11]), .phy_rx_dv(drv_r[12]), .phy_tx_clk(drv_r[13]),
      .phy_rx_clk(drv_r[14]), .mac_tx_en(drv_r[15]), .rom_data_pin_out(d_out), .rom_data_pin_oe(d_oe),
      .rom_clock_pin_out(c_out));
   pins_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_drv(drv_r[5:3]), .ext_val(drv_r[8:6]),
      .pin_in(pin_in));
   // Clock, 4 ns period
   always #2 pclk = ~pclk;
   // Random source, shift register with feedback taps
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Value a pin should carry: lamp state or data bit
   function automatic logic [2:0] v_exp(input logic [31:0] c);
      return (c[30:28] & drv_r[2:0]) | (~c[30:28] & c[2:0]);
   endfunction
   // Open drain only drives a low, so a high leaves the pin released
   function automatic logic [2:0] oe_exp(input logic [31:0] c);
      return (c[30:28] | c[10:8]) & (c[18:16] | ~v_exp(c));
   endfunction
   function automatic logic [2:0] lvl(input logic [31:0] c);
      return (oe_exp(c) & v_exp(c)) | (~oe_exp(c) & (drv_r[5:3] & drv_r[8:6] | ~drv_r[5:3]));
   endfunction
   // Rom pin mux as {data enable, data, clock}
   function automatic logic [2:0] mux_exp(input logic [31:0] c);
      case (c[22:20])
         3'h0: return {drv_r[10], drv_r[9] & drv_r[10], drv_r[11]};
         3'h1: return {1'b1, c[3], c[4]};
         3'h3: return {1'b1, c[3], drv_r[12]};
         3'h5: return {1'b1, drv_r[15], c[4]};
         3'h6: return {1'b1, drv_r[15], drv_r[12]};
         default: return {1'b1, drv_r[13], drv_r[14]};
      endcase
   endfunction
   // One bus transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Ready and data taken at the rising edge, before the slave's own update lands
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) n_mismatch++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Watchdog, far beyond the roughly nine hundred cycles the run needs
   initial begin
      #100000;
      n_mismatch++;
      finish_test();
   end
   // Main sequence
   initial begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata, drv_r} = '0;
      seed = 32'h00000029;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `PIN_CFG_ADDR, 32'h0, rd, er);
      `CHK("cfg after reset", 32'h00000007, rd)
      apb(1'b0, 12'h100, 32'h0, rd, er);
      `CHK("unmapped error", 1'b1, er)
      for (int t = 0; t < 24; t++) begin
         seed = nxt(seed);
         stim = seed[15:0];
         // Rom engine kept quiet while the select field moves
         drv_r <= stim & 16'hf1ff;
         seed = nxt(seed);
         w = seed & `CFG_WRITE_MASK;
         w[22:20] = codes[t % 6];
         en = seed[13:11];
         apb(1'b1, `PIN_CFG_ADDR, w, rd, er);
         apb(1'b1, `IRQ_ENABLE_ADDR, {29'h0, en}, rd, er);
         apb(1'b0, `IRQ_ENABLE_ADDR, 32'h0, rd, er);
         `CHK("irq enable", {29'h0, en}, rd)
         drv_r <= stim;
         repeat (6) @(posedge pclk);
         `CHK("pin_oe", oe_exp(w), pin_oe)
         `CHK("pin_out", oe_exp(w) & v_exp(w), pin_out & pin_oe)
         `CHK("rom mux", mux_exp(w), {d_oe, d_out & d_oe, c_out})
         apb(1'b0, `IRQ_STATUS_ADDR, 32'h0, rd, er);
         repeat (6) @(posedge pclk);
         apb(1'b0, `IRQ_STATUS_ADDR, 32'h0, rd, er);
         act = ~(lvl(w) ^ w[26:24]);
         `CHK("irq status", act, rd[2:0])
         apb(1'b0, `PIN_CFG_ADDR, 32'h0, rd, er);
         `CHK("cfg read", {w[31:3], lvl(w)}, rd)
         `CHK("irq", |(act & en), irq)
         $display("test %0d done", t);
      end
      finish_test();
   end
endmodule
